// [rtl/fsptm_pkg.sv]
package fsptm_pkg;

  // widths
  localparam int FREQ_W = 16;    // frequency in 0.01 Hz units
  localparam int CODE_W = 12;    // binary setpoint code
  localparam int HALF_W = 6;     // one entered half of the code
  localparam int SW_N   = 8;     // switch inputs
  localparam int FUNC_W = 5;     // terminal function code width
  localparam int MODE_W = 4;     // setpoint source select width
  localparam int RATE_W = 16;    // ramp interval counter width

  // setpoint source modes; 5..9 are other sources, held here
  localparam logic [MODE_W-1:0] MODE_KEY_SAVE   = 4'h0;
  localparam logic [MODE_W-1:0] MODE_KEY_NOSAVE = 4'h1;
  localparam logic [MODE_W-1:0] MODE_TERM_UPDN  = 4'h2;
  localparam logic [MODE_W-1:0] MODE_TERM_MEMO  = 4'h3;
  localparam logic [MODE_W-1:0] MODE_BINARY     = 4'h4;
  localparam logic [MODE_W-1:0] MODE_LAST       = 4'h9;

  // terminal function codes
  localparam logic [FUNC_W-1:0] FUNC_UP    = 5'h0c;
  localparam logic [FUNC_W-1:0] FUNC_DOWN  = 5'h0d;
  localparam logic [FUNC_W-1:0] FUNC_CLEAR = 5'h0e;

  // binary mode pin positions inside the switch input vector, and half positions inside the code
  localparam int BIN_DATA_LSB = 0;
  localparam int BIN_STB_B    = 6;
  localparam int BIN_STB_A    = 7;
  localparam int HALF_LO_LSB  = 0;
  localparam int HALF_HI_LSB  = 6;

  // scaling: freq = highest * code / 4095, rounded to nearest
  localparam int CODE_FULL = 4095;
  localparam int CODE_HALF = 2047;

  // reset and step values
  localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
  localparam logic [FREQ_W-1:0] FREQ_STEP = 16'h0001;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [RATE_W-1:0] RATE_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    FSPTM_RUN,
    FSPTM_STOPPING,
    FSPTM_STOPPED
  } fsptm_drive_t;

  typedef enum logic {
    FSPTM_BOOT,
    FSPTM_LIVE
  } fsptm_phase_t;

  typedef struct packed {
    logic up;
    logic down;
    logic clear;
  } fsptm_updn_t;

  typedef struct packed {
    logic [FREQ_W-1:0] highest;
    logic [FREQ_W-1:0] upper;
    logic [FREQ_W-1:0] lower;
  } fsptm_limits_t;

endpackage

// [rtl/fsptm_rate_tick.sv]
// one-cycle tick every (rate+1) cycles while enabled
module fsptm_rate_tick
  import fsptm_pkg::*;
#(
  parameter int CNT_W = RATE_W
) (
  input  wire logic             sys_clk,  // system clock
  input  wire logic             rst_b,    // sync reset, active low
  input  wire logic             run_en,   // count while high
  input  wire logic [CNT_W-1:0] rate,     // interval minus one
  output logic                  tick      // one-cycle step pulse
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;

  // restart on every fresh press so the first step waits a full interval
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run_en) begin
      cnt_d = '0;
    end else if (cnt_q >= rate) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// [rtl/fsptm_code_scale.sv]
// registered scaling of the binary code into a frequency
module fsptm_code_scale
  import fsptm_pkg::*;
(
  input  wire logic              sys_clk,  // system clock
  input  wire logic              rst_b,    // sync reset, active low
  input  wire logic [CODE_W-1:0] code,     // 12-bit setpoint code
  input  wire logic [FREQ_W-1:0] highest,  // configured highest frequency
  output logic      [FREQ_W-1:0] freq      // scaled frequency
);

  localparam int PROD_W = FREQ_W + CODE_W;

  logic [PROD_W-1:0] prod;
  logic [PROD_W-1:0] quot;
  logic [FREQ_W-1:0] freq_q;
  logic [FREQ_W-1:0] freq_d;

  // rounding keeps 2048 -> 30.01 Hz at 60 Hz full scale; constant divisor
  always_comb begin
    prod   = PROD_W'(highest) * PROD_W'(code);
    quot   = (prod + PROD_W'(CODE_HALF)) / PROD_W'(CODE_FULL);
    freq_d = quot[FREQ_W-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      freq_q <= FREQ_ZERO;
    end else begin
      freq_q <= freq_d;
    end
  end

  assign freq = freq_q;

endmodule

// [rtl/fsptm_setpoint.sv]
module fsptm_setpoint
  import fsptm_pkg::*;
(
  input  wire logic                         sys_clk,                        // system clock
  input  wire logic                         rst_b,                          // sync reset, low
  input  wire logic [MODE_W-1:0]            setpoint_source_select,         // source mode
  input  wire fsptm_drive_t                 drive_state,                    // run/stopping/stopped
  input  wire logic                         stop_accept,                    // stop taken, pulse
  input  wire logic                         run_start,                      // run begins, pulse
  input  wire logic                         power_fail,                     // power fail, pulse
  input  wire logic [FREQ_W-1:0]            stored_freq_setpoint,           // stored setpoint
  input  wire logic                         stored_wr,                      // setpoint written
  input  wire logic                         key_up,                         // keypad up, pulse
  input  wire logic                         key_down,                       // keypad down, pulse
  input  wire logic [RATE_W-1:0]            updown_ramp_rate,               // step interval
  input  wire fsptm_limits_t                freq_limits,                    // highest/upper/lower
  input  wire logic [SW_N-1:0]              switch_inputs_all,              // 1 = closed
  input  wire logic [SW_N-1:0][FUNC_W-1:0]  input_terminal_function_assign, // per-input function
  output logic      [FREQ_W-1:0]            present_freq,                   // present frequency
  output logic                              stored_save,                    // save strobe
  output logic      [FREQ_W-1:0]            stored_save_data,               // value to save
  output logic      [CODE_W-1:0]            setpoint_code,                  // binary code
  output logic      [SW_N-1:0]              terminal_func_en                // normal functions on
);

  fsptm_phase_t      phase_q;
  fsptm_phase_t      phase_d;
  logic [FREQ_W-1:0] freq_q;
  logic [FREQ_W-1:0] freq_d;
  logic [FREQ_W-1:0] memo_q;
  logic [FREQ_W-1:0] memo_d;
  logic              save_q;
  logic              save_d;
  logic [FREQ_W-1:0] save_data_q;
  logic [FREQ_W-1:0] save_data_d;
  logic [CODE_W-1:0] code_q;
  logic [CODE_W-1:0] code_d;
  logic [1:0]        pair_q;
  logic [1:0]        pair_d;
  logic [SW_N-1:0]   func_en_q;
  logic [SW_N-1:0]   func_en_d;
  fsptm_updn_t       term;
  logic              mode_key;
  logic              mode_term;
  logic              mode_bin;
  logic              clear_live;
  logic              step_live;
  logic              ramp_en;
  logic              ramp_tick;
  logic [FREQ_W-1:0] scaled_freq;
  logic [1:0]        pair_now;
  logic [HALF_W-1:0] bin_data;

  // saturating step inside the configured lower and upper limits
  function automatic logic [FREQ_W-1:0] step_clamp(
    input logic [FREQ_W-1:0] cur,
    input logic              up,
    input fsptm_limits_t     lim
  );
    logic [FREQ_W:0] nxt;
    nxt = '0;
    if (up) begin
      nxt = {1'b0, cur} + {1'b0, FREQ_STEP};
    end else if (cur > FREQ_STEP) begin
      nxt = {1'b0, cur - FREQ_STEP};
    end
    if (nxt > {1'b0, lim.upper}) begin
      nxt = {1'b0, lim.upper};
    end
    if (nxt < {1'b0, lim.lower}) begin
      nxt = {1'b0, lim.lower};
    end
    return nxt[FREQ_W-1:0];
  endfunction

  // mode decode; values above 9 fall into the hold branch
  always_comb begin
    mode_key  = (setpoint_source_select == MODE_KEY_SAVE) ||
                (setpoint_source_select == MODE_KEY_NOSAVE);
    mode_term = (setpoint_source_select == MODE_TERM_UPDN) ||
                (setpoint_source_select == MODE_TERM_MEMO);
    mode_bin  = (setpoint_source_select == MODE_BINARY);
  end

  // terminal function decode; the user must map codes 12/13/14
  always_comb begin
    term = '0;
    for (int i = 0; i < SW_N; i++) begin
      if (input_terminal_function_assign[i] == FUNC_UP) begin
        term.up = term.up | switch_inputs_all[i];
      end
      if (input_terminal_function_assign[i] == FUNC_DOWN) begin
        term.down = term.down | switch_inputs_all[i];
      end
      if (input_terminal_function_assign[i] == FUNC_CLEAR) begin
        term.clear = term.clear | switch_inputs_all[i];
      end
    end
  end

  // which terminals count in the present drive state
  always_comb begin
    clear_live = mode_term && (drive_state != FSPTM_STOPPED ||
                 setpoint_source_select == MODE_TERM_MEMO);
    step_live  = mode_term && (drive_state == FSPTM_RUN);
    ramp_en    = step_live && !term.clear && (term.up ^ term.down);
  end

  // interval timer for held up/down terminals
  fsptm_rate_tick #(
    .CNT_W (RATE_W)
  ) u_rate (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run_en  (ramp_en),
    .rate    (updown_ramp_rate),
    .tick    (ramp_tick)
  );

  // code to frequency, one register stage
  fsptm_code_scale u_scale (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .code    (code_q),
    .highest (freq_limits.highest),
    .freq    (scaled_freq)
  );

  // binary entry: closed switch is 1, open is 0
  always_comb begin
    pair_now = {switch_inputs_all[BIN_STB_A], switch_inputs_all[BIN_STB_B]};
    bin_data = switch_inputs_all[BIN_DATA_LSB +: HALF_W];
  end

  // capture on entry to a split strobe state; equal levels only hold
  always_comb begin
    pair_d = pair_now;
    code_d = code_q;
    if (mode_bin && pair_now != pair_q) begin
      if (pair_now == 2'b10) begin
        code_d[HALF_HI_LSB +: HALF_W] = bin_data;
      end else if (pair_now == 2'b01) begin
        code_d[HALF_LO_LSB +: HALF_W] = bin_data;
      end
    end
  end

  // the code register clears at power-up so binary mode starts at zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pair_q <= 2'b00;
      code_q <= CODE_ZERO;
    end else begin
      pair_q <= pair_d;
      code_q <= code_d;
    end
  end

  // present frequency, memo and power-fail save
  always_comb begin
    phase_d     = FSPTM_LIVE;
    freq_d      = freq_q;
    memo_d      = memo_q;
    save_d      = 1'b0;
    save_data_d = save_data_q;
    case (phase_q)
      FSPTM_BOOT: begin
        // first cycle after reset: power-up load
        if (mode_key) begin
          freq_d = stored_freq_setpoint;
        end else begin
          freq_d = FREQ_ZERO;
        end
      end
      FSPTM_LIVE: begin
        if (mode_key) begin
          // stored setpoint is only an input; keys never write it back
          if (stored_wr) begin
            freq_d = stored_freq_setpoint;
          end else if (key_up && !key_down) begin
            freq_d = step_clamp(freq_q, 1'b1, freq_limits);
          end else if (key_down && !key_up) begin
            freq_d = step_clamp(freq_q, 1'b0, freq_limits);
          end
          if (power_fail && setpoint_source_select == MODE_KEY_SAVE) begin
            save_d      = 1'b1;
            save_data_d = freq_q;
          end
        end else if (mode_term) begin
          if (clear_live && term.clear) begin
            freq_d = FREQ_ZERO;
          end else if (ramp_tick && step_live) begin
            freq_d = step_clamp(freq_q, term.up, freq_limits);
          end
          if (setpoint_source_select == MODE_TERM_MEMO) begin
            if (stop_accept) begin
              memo_d = freq_q;
            end
            if (run_start) begin
              freq_d = memo_q;
            end
          end
        end else if (mode_bin) begin
          freq_d = scaled_freq;
        end
      end
      default: begin
        phase_d = FSPTM_BOOT;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_q     <= FSPTM_BOOT;
      freq_q      <= FREQ_ZERO;
      memo_q      <= FREQ_ZERO;
      save_q      <= 1'b0;
      save_data_q <= FREQ_ZERO;
    end else begin
      phase_q     <= phase_d;
      freq_q      <= freq_d;
      memo_q      <= memo_d;
      save_q      <= save_d;
      save_data_q <= save_data_d;
    end
  end

  // binary mode takes all eight inputs away from their normal functions
  always_comb begin
    func_en_d = mode_bin ? '0 : '1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      func_en_q <= '1;
    end else begin
      func_en_q <= func_en_d;
    end
  end

  assign present_freq     = freq_q;
  assign stored_save      = save_q;
  assign stored_save_data = save_data_q;
  assign setpoint_code    = code_q;
  assign terminal_func_en = func_en_q;

endmodule

// [sim/fsptm_chk.sv]
module fsptm_chk
  import fsptm_pkg::*;
(
  input wire logic                        sys_clk,                       // clock
  input wire logic                        rst_b,                         // reset, low
  input wire logic [MODE_W-1:0]           setpoint_source_select,        // mode
  input wire fsptm_drive_t                drive_state,                   // drive state
  input wire logic                        run_start,                     // run pulse
  input wire logic                        power_fail,                    // power fail pulse
  input wire logic [FREQ_W-1:0]           stored_freq_setpoint,          // stored value
  input wire logic                        stored_wr,                     // stored write
  input wire logic                        key_up,                        // key up
  input wire logic                        key_down,                      // key down
  input wire fsptm_limits_t               freq_limits,                   // limits
  input wire logic [SW_N-1:0]             switch_inputs_all,             // switches
  input wire logic [SW_N-1:0][FUNC_W-1:0] input_terminal_function_assign, // functions
  input wire logic [FREQ_W-1:0]           present_freq,                  // frequency
  input wire logic                        stored_save,                   // save strobe
  input wire logic [FREQ_W-1:0]           stored_save_data,              // save value
  input wire logic [CODE_W-1:0]           setpoint_code,                 // binary code
  input wire logic [SW_N-1:0]             terminal_func_en               // normal functions
);
  timeunit 1ns;
  timeprecision 100ps;
  logic              live_q;  // past the boot edge
  logic              clr_in;  // any clear input closed
  logic [FREQ_W-1:0] scaled;  // expected binary frequency
  wire kp = setpoint_source_select <= MODE_KEY_NOSAVE;
  wire tm = setpoint_source_select == MODE_TERM_UPDN || setpoint_source_select == MODE_TERM_MEMO;
  wire [1:0] stb = switch_inputs_all[BIN_STB_A:BIN_STB_B];
  // $past is only trusted once reset has been gone a full cycle
  always_ff @(posedge sys_clk) live_q <= rst_b;
  // clear input may sit on any terminal
  always_comb begin
    clr_in = 1'b0;
    for (int i = 0; i < SW_N; i++)
      if (input_terminal_function_assign[i] == FUNC_CLEAR && switch_inputs_all[i]) clr_in = 1'b1;
    scaled = FREQ_W'((32'(freq_limits.highest) * 32'(setpoint_code) + CODE_HALF) / CODE_FULL);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_bin_steady;
    (setpoint_source_select == MODE_BINARY && $stable(setpoint_code) && $stable(freq_limits))[*6];
  endsequence
  AST_STORED_WR:
  assert property (live_q && kp && stored_wr |=> present_freq == $past(stored_freq_setpoint))
    else $error("stored write not taken");
  AST_KEY_UP:
  assert property (live_q && kp && !stored_wr && key_up && !key_down
    && present_freq < freq_limits.upper && present_freq >= freq_limits.lower
    |=> present_freq == $past(present_freq) + FREQ_STEP) else $error("key step wrong");
  AST_SAVE:
  assert property (power_fail && setpoint_source_select == MODE_KEY_SAVE
    |=> stored_save && stored_save_data == $past(present_freq)) else $error("save missing");
  AST_NOSAVE:
  assert property (!(power_fail && setpoint_source_select == MODE_KEY_SAVE) |=> !stored_save)
    else $error("save without power fail");
  AST_CLEAR:
  assert property (live_q && tm && clr_in && !run_start && (drive_state != FSPTM_STOPPED
    || setpoint_source_select == MODE_TERM_MEMO) |=> present_freq == FREQ_ZERO)
    else $error("clear not applied");
  AST_HOLD:
  assert property (live_q && tm && !run_start && (drive_state != FSPTM_RUN && !clr_in
    || drive_state == FSPTM_STOPPED && setpoint_source_select == MODE_TERM_UPDN)
    |=> present_freq == $past(present_freq)) else $error("terminals not ignored");
  AST_BIN_HOLD:
  assert property (live_q && stb[1] == stb[0] |=> $stable(setpoint_code))
    else $error("code moved while strobes equal");
  AST_BIN_CAP:
  assert property (live_q && setpoint_source_select == MODE_BINARY && stb[1] != stb[0]
    && stb != $past(stb) |=> setpoint_code == ($past(stb[1])
    ? {$past(switch_inputs_all[5:0]), $past(setpoint_code[5:0])}
    : {$past(setpoint_code[11:6]), $past(switch_inputs_all[5:0])})) else $error("bad capture");
  AST_BIN_FREQ:
  assert property (live_q ##0 s_bin_steady |-> present_freq == scaled)
    else $error("binary frequency wrong");
  AST_FUNC_EN:
  assert property (live_q |=> terminal_func_en
    == ($past(setpoint_source_select) == MODE_BINARY ? 8'h00 : 8'hff)) else $error("func_en");
endmodule

bind fsptm_setpoint fsptm_chk fsptm_chk_i (.sys_clk, .rst_b, .setpoint_source_select,
  .drive_state, .run_start, .power_fail, .stored_freq_setpoint, .stored_wr, .key_up,
  .key_down, .freq_limits, .switch_inputs_all, .input_terminal_function_assign,
  .present_freq, .stored_save, .stored_save_data, .setpoint_code, .terminal_func_en);

// [sim/fsptm_sw_model.sv]
module fsptm_sw_model
  import fsptm_pkg::*;
(
  input  wire logic            sys_clk,  // system clock
  output logic      [SW_N-1:0] sw        // switch levels, 1 = closed
);
  timeunit 1ns;
  timeprecision 100ps;
  // all switches open at power-up
  initial sw = '0;
  // up on input 0, down on 1, clear on 2; closed reads 1
  task automatic terms(input logic [2:0] cdu);
    sw[2:0] = cdu;
  endtask
  // one half entry; data first, strobe change later, then data disturbed
  task automatic half(input logic hi, input logic idle, input logic [HALF_W-1:0] d);
    sw[7:6] = {idle, idle};
    @(posedge sys_clk);
    #1;
    sw[5:0] = d;
    @(posedge sys_clk);
    #1;
    sw[7:6] = hi ? 2'b10 : 2'b01;
    repeat (2) @(posedge sys_clk);
    #1;
    sw[7:6] = {idle, idle};
    sw[5:0] = ~d;  // switches move on; code must not follow
  endtask
endmodule

// [sim/fsptm_setpoint_tb.sv]
module fsptm_setpoint_tb;
  import fsptm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        sys_clk, rst_b, stp, run, pf, wr, ku, kd, save;
  logic [MODE_W-1:0]           mode;
  fsptm_drive_t                drv;
  logic [FREQ_W-1:0]           stored, freq, sdata, exp;
  logic [RATE_W-1:0]           rate;
  fsptm_limits_t               lim;
  logic [SW_N-1:0]             sw, fen;
  logic [SW_N-1:0][FUNC_W-1:0] fa;
  logic [CODE_W-1:0]           code, c;
  int                          bad_count, checked, h;

  fsptm_setpoint fsptm_setpoint_i (.sys_clk, .rst_b, .setpoint_source_select(mode),
    .drive_state(drv), .stop_accept(stp), .run_start(run), .power_fail(pf),
    .stored_freq_setpoint(stored), .stored_wr(wr), .key_up(ku), .key_down(kd),
    .updown_ramp_rate(rate), .freq_limits(lim), .switch_inputs_all(sw),
    .input_terminal_function_assign(fa), .present_freq(freq), .stored_save(save),
    .stored_save_data(sdata), .setpoint_code(code), .terminal_func_en(fen));
  fsptm_sw_model fsptm_sw_model_i (.sys_clk, .sw);

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [FREQ_W-1:0] seen, input logic [FREQ_W-1:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input logic [MODE_W-1:0] m);
    mode = m;
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    cyc(2);
  endtask
  // hold a terminal pattern, release, then compare
  task automatic updn(input fsptm_drive_t ds, input logic [2:0] cdu, input logic [15:0] e);
    drv = ds;
    fsptm_sw_model_i.terms(cdu);
    cyc(h);
    fsptm_sw_model_i.terms(3'b000);
    cyc(2);
    chk(freq, e);
  endtask
  // rounded scaling of the binary code
  function automatic logic [FREQ_W-1:0] scale(input logic [15:0] hf, input logic [11:0] v);
    return FREQ_W'((32'(hf) * 32'(v) + CODE_HALF) / CODE_FULL);
  endfunction

  // hang guard
  initial begin
    #40000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'he7b1_3e1e));
    {stp, run, pf, wr, ku, kd} = '0;
    drv = FSPTM_RUN;
    stored = 16'h01f4;
    rate = 16'h0003;
    lim = {16'h1770, 16'h1770, 16'h0000};
    fa = '0;
    fa[0] = FUNC_UP;
    fa[1] = FUNC_DOWN;
    fa[2] = FUNC_CLEAR;
    do_reset(MODE_KEY_SAVE);
    chk(freq, 16'h01f4);
    exp = 16'h01f4;
    // random keys and writes near the upper limit
    for (int i = 0; i < 60; i++) begin
      wr = $urandom_range(0, 7) == 0;
      {ku, kd} = 2'($urandom);
      stored = 16'h1760 + 16'($urandom_range(0, 16));
      if (wr) exp = stored;
      else if (ku && !kd && exp < lim.upper) exp++;
      else if (kd && !ku && exp > lim.lower) exp--;
      cyc(1);
      chk(freq, exp);
      chk(16'(save), 16'h0000);
    end
    {wr, ku, kd} = '0;
    // power fail in every mode
    for (int m = 0; m <= 9; m++) begin
      mode = MODE_W'(m);
      pf = 1'b1;
      cyc(1);
      pf = 1'b0;
      chk(16'(save), 16'(m == 0));
      if (m == 0) chk(sdata, exp);
    end
    rate = 16'($urandom_range(2, 6));
    h = 4 * (int'(rate) + 1) + 2;
    mode = MODE_TERM_UPDN;
    updn(FSPTM_RUN, 3'b001, 16'h0004);
    updn(FSPTM_RUN, 3'b011, 16'h0004);
    updn(FSPTM_STOPPING, 3'b001, 16'h0004);
    updn(FSPTM_STOPPED, 3'b100, 16'h0004);
    updn(FSPTM_STOPPED, 3'b010, 16'h0004);
    updn(FSPTM_STOPPING, 3'b100, 16'h0000);
    updn(FSPTM_RUN, 3'b001, 16'h0004);
    updn(FSPTM_RUN, 3'b101, 16'h0000);
    mode = MODE_TERM_MEMO;
    updn(FSPTM_RUN, 3'b001, 16'h0004);
    drv = FSPTM_STOPPING;
    stp = 1'b1;
    cyc(1);
    stp = 1'b0;
    updn(FSPTM_STOPPED, 3'b001, 16'h0004);
    updn(FSPTM_STOPPED, 3'b100, 16'h0000);
    run = 1'b1;
    drv = FSPTM_RUN;
    cyc(1);
    run = 1'b0;
    cyc(1);
    chk(freq, 16'h0004);
    // binary entry, lower half first, running or stopped
    mode = MODE_BINARY;
    for (int i = 0; i < 12; i++) begin
      c = i == 0 ? 12'hfff : (i == 1 ? 12'h000 : 12'($urandom));
      lim.highest = i < 2 ? 16'h1770 : 16'($urandom_range(1, 65535));
      lim.upper = lim.highest;
      drv = $urandom_range(0, 1) ? FSPTM_RUN : FSPTM_STOPPED;
      h = $urandom_range(0, 1);
      fsptm_sw_model_i.half(1'b0, h[0], c[5:0]);
      fsptm_sw_model_i.half(1'b1, h[0], c[11:6]);
      cyc(4);
      chk(16'(code), 16'(c));
      chk(freq, scale(lim.highest, c));
      chk(16'(fen), 16'h0000);
    end
    do_reset(MODE_BINARY);
    chk(freq, 16'h0000);
    mode = MODE_KEY_NOSAVE;
    cyc(2);
    chk(16'(fen), 16'h00ff);
    finish_test();
  end
endmodule
